// ===== slk_top.v
// protection locking and permanent sector lockdown logic of a serial flash
// assumes serial pins and the write-protect pin arrive asynchronously
// and are oversampled by i_clock; program/erase requests come from same-clock logic
`timescale 1ns/1ps
`include "slk_defines.vh"

module slk_top #(
  parameter NUM_SECTORS        = `SLK_NUM_SECTORS,
  parameter SECTOR_IDX_W       = `SLK_SECTOR_IDX_W,
  parameter LOCK_COMMIT_CYCLES = `SLK_LOCK_COMMIT_NS / `SLK_CLK_PERIOD_NS
) (
  input  wire                   i_clock,
  input  wire                   i_rst_b,
  input  wire                   i_clk_en,
  input  wire                   i_spi_sck,
  input  wire                   i_spi_cs_n,
  input  wire                   i_spi_si,
  input  wire                   i_wp_n,
  input  wire                   i_nv_init,
  input  wire                   i_pe_req,
  input  wire [23:0]            i_pe_addr,
  output wire [NUM_SECTORS-1:0] o_sector_prot,
  output wire [NUM_SECTORS-1:0] o_sector_lockdown,
  output wire                   o_write_enable_latch_bit,
  output wire                   o_protection_regs_locked_bit,
  output wire                   o_lockdown_enable_bit,
  output wire                   o_lockdown_frozen,
  output wire                   o_hw_locked,
  output wire                   o_sw_locked,
  output wire                   o_lock_busy,
  output reg                    o_pe_done,
  output reg                    o_pe_refused
);

  localparam NV_AW = SECTOR_IDX_W + 1;
  localparam [NV_AW-1:0] FREEZE_IDX = NUM_SECTORS[NV_AW-1:0];
  localparam [15:0] COMMIT_LOAD = LOCK_COMMIT_CYCLES[15:0];

  // reset release
  reg        rst_meta;
  reg        rst_b;

  // synchronised pins
  wire [3:0] pins_f;
  wire       sck_f;
  wire       cs_n_f;
  wire       si_f;
  wire       wp_n_f;
  reg        sck_prev;
  reg        cs_n_prev;
  wire       sck_rise;
  wire       frame_end;
  wire       cs_active;

  // serial framing
  reg  [6:0]  shift;
  reg  [2:0]  bit_cnt;
  reg  [2:0]  byte_cnt;
  reg  [7:0]  opcode;
  reg  [23:0] addr;
  reg  [7:0]  confirm;
  wire [7:0]  byte_in;

  // device state
  reg                   write_enable_latch_bit;
  reg                   protection_regs_locked_bit;
  reg                   lockdown_enable_bit;
  reg [NUM_SECTORS-1:0] prot;
  reg [15:0]            commit_cnt;

  // nonvolatile store
  wire [NUM_SECTORS:0]  nv_bits;
  wire                  nv_rd_bit;
  reg                   nv_set_we;
  reg  [NV_AW-1:0]      nv_set_idx;
  wire [NV_AW-1:0]      nv_rd_idx;
  wire                  frozen;

  // decode
  wire                    wp_asserted;
  wire                    hw_locked;
  wire                    on_boundary;
  wire [SECTOR_IDX_W-1:0] sect_idx;
  wire [SECTOR_IDX_W-1:0] pe_idx;
  wire [3:0]              global_code;
  wire                    lock_seq_ok;
  wire                    freeze_seq_ok;
  wire                    lockdown_usable;

  // program/erase check pipeline
  reg                     pe_pend;
  reg                     pe_prot;

  always @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta <= 1'b0;
      rst_b    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_b    <= rst_meta;
    end
  end

  slk_sync #(
    .W         (4),
    .RESET_VAL (`SLK_PIN_RESET)
  ) u_sync (
    .i_clock  (i_clock),
    .i_rst_b  (rst_b),
    .i_clk_en (i_clk_en),
    .i_async  ({i_spi_sck, i_spi_cs_n, i_spi_si, i_wp_n}),
    .o_sync   (pins_f)
  );

  assign sck_f  = pins_f[3];
  assign cs_n_f = pins_f[2];
  assign si_f   = pins_f[1];
  assign wp_n_f = pins_f[0];

  assign wp_asserted = ~wp_n_f;
  assign hw_locked   = wp_asserted & protection_regs_locked_bit;

  assign cs_active = ~cs_n_f;
  assign sck_rise  = cs_active & sck_f & ~sck_prev;
  assign frame_end = cs_n_f & ~cs_n_prev;
  assign byte_in   = {shift, si_f};

  always @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_prev  <= 1'b0;
      cs_n_prev <= 1'b1;
    end
    else if (i_clk_en)
    begin
      sck_prev  <= sck_f;
      cs_n_prev <= cs_n_f;
    end
  end

  // byte assembly; bytes past the confirmation are dropped
  always @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift    <= 7'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      opcode   <= 8'h00;
      addr     <= 24'h000000;
      confirm  <= 8'h00;
    end
    else if (i_clk_en)
    begin
      if (!cs_active)
      begin
        if (!cs_n_prev)
        begin
          bit_cnt  <= bit_cnt;
          byte_cnt <= byte_cnt;
        end
        else
        begin
          bit_cnt  <= 3'h0;
          byte_cnt <= 3'h0;
        end
      end
      else if (sck_rise)
      begin
        shift   <= byte_in[6:0];
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7)
        begin
          if (byte_cnt != `SLK_BYTES_CONFIRM)
            byte_cnt <= byte_cnt + 3'h1;
          case (byte_cnt)
            3'h0:    opcode        <= byte_in;
            3'h1:    addr[23:16]   <= byte_in;
            3'h2:    addr[15:8]    <= byte_in;
            3'h3:    addr[7:0]     <= byte_in;
            3'h4:    confirm       <= byte_in;
            default: confirm       <= confirm;
          endcase
        end
      end
    end
  end

  assign on_boundary = (bit_cnt == 3'h0);
  assign sect_idx    = addr[`SLK_SECTOR_SHIFT +: SECTOR_IDX_W];
  assign global_code = addr[16 + `SLK_SR1_GLOBAL_MSB : 16 + `SLK_SR1_GLOBAL_LSB];
  assign frozen      = nv_bits[NUM_SECTORS];

  // full address, correct confirmation, clean end
  assign lock_seq_ok = on_boundary & (byte_cnt == `SLK_BYTES_CONFIRM)
                     & (confirm == `SLK_CONFIRM);
  assign freeze_seq_ok = lock_seq_ok & (addr == `SLK_FREEZE_ADDR);
  assign lockdown_usable = lockdown_enable_bit & ~frozen & write_enable_latch_bit;

  // command execution at the end of each frame; frames during a commit are dropped
  always @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      write_enable_latch_bit        <= 1'b0;
      // reset, or a status write with bit 7 clear outside hardware lock, returns the locked bit to 0
      protection_regs_locked_bit       <= 1'b0;
      lockdown_enable_bit        <= 1'b0;
      prot       <= `SLK_PROT_RESET;
      nv_set_we  <= 1'b0;
      nv_set_idx <= {NV_AW{1'b0}};
      commit_cnt <= 16'h0000;
    end
    else if (i_clk_en)
    begin
      nv_set_we <= 1'b0;
      if (commit_cnt != 16'h0000)
        commit_cnt <= commit_cnt - 16'h0001;
      // freeze forces the enable low for ever
      if (frozen)
        lockdown_enable_bit <= 1'b0;
      if (frame_end && commit_cnt == 16'h0000)
      begin
        case (opcode)
          `SLK_OP_WRITE_ENABLE:
          begin
            if (on_boundary && byte_cnt == `SLK_BYTES_OPCODE)
              write_enable_latch_bit <= 1'b1;
          end
          `SLK_OP_WRITE_DISABLE:
          begin
            write_enable_latch_bit <= 1'b0;
          end
          `SLK_OP_WRITE_STATUS1:
          begin
            write_enable_latch_bit <= 1'b0;
            // status write ignored under hardware lock
            if (write_enable_latch_bit && !hw_locked && on_boundary && byte_cnt >= `SLK_BYTES_STATUS)
            begin
              // rise at any level, fall only when released
              protection_regs_locked_bit <= addr[16 + `SLK_SR1_LOCKED_BIT];
              // no global operation while the bit was already set
              if (!protection_regs_locked_bit)
              begin
                if (global_code == `SLK_GLOBAL_UNPROTECT)
                  prot <= {NUM_SECTORS{1'b0}};
                else if (global_code == `SLK_GLOBAL_PROTECT)
                  prot <= {NUM_SECTORS{1'b1}};
              end
            end
          end
          `SLK_OP_WRITE_STATUS2:
          begin
            write_enable_latch_bit <= 1'b0;
            if (write_enable_latch_bit && !frozen && on_boundary && byte_cnt >= `SLK_BYTES_STATUS)
              lockdown_enable_bit <= addr[16 + `SLK_SR2_LOCKDOWN_EN];
          end
          `SLK_OP_PROTECT_SECTOR,
          `SLK_OP_UNPROTECT_SECT:
          begin
            write_enable_latch_bit <= 1'b0;
            // both locked states refuse per-sector commands
            if (write_enable_latch_bit && !protection_regs_locked_bit && on_boundary && byte_cnt >= `SLK_BYTES_ADDRESS)
              prot[sect_idx] <= (opcode == `SLK_OP_PROTECT_SECTOR);
          end
          `SLK_OP_LOCKDOWN:
          begin
            // abort or ignore still clears the latch
            write_enable_latch_bit <= 1'b0;
            // set sector bit and start the commit time
            if (lockdown_usable && lock_seq_ok)
            begin
              nv_set_we  <= 1'b1;
              nv_set_idx <= {1'b0, sect_idx};
              commit_cnt <= COMMIT_LOAD;
            end
          end
          `SLK_OP_FREEZE:
          begin
            write_enable_latch_bit <= 1'b0;
            if (lockdown_usable && freeze_seq_ok)
            begin
              nv_set_we  <= 1'b1;
              nv_set_idx <= FREEZE_IDX;
              lockdown_enable_bit        <= 1'b0;
              commit_cnt <= COMMIT_LOAD;
            end
          end
          default:
          begin
            write_enable_latch_bit <= write_enable_latch_bit;
          end
        endcase
      end
    end
  end

  slk_nvbits #(
    .N  (NUM_SECTORS + 1),
    .AW (NV_AW)
  ) u_nvbits (
    .i_clock   (i_clock),
    .i_clk_en  (i_clk_en),
    .i_init    (i_nv_init),
    .i_set_we  (nv_set_we),
    .i_set_idx (nv_set_idx),
    .i_rd_idx  (nv_rd_idx),
    .o_rd_bit  (nv_rd_bit),
    .o_bits    (nv_bits)
  );

  assign pe_idx    = i_pe_addr[`SLK_SECTOR_SHIFT +: SECTOR_IDX_W];
  assign nv_rd_idx = {1'b0, pe_idx};

  // program/erase gate: answer two cycles after the request
  always @(posedge i_clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pe_pend      <= 1'b0;
      pe_prot      <= 1'b0;
      o_pe_done    <= 1'b0;
      o_pe_refused <= 1'b0;
    end
    else if (i_clk_en)
    begin
      pe_pend   <= i_pe_req;
      // protection bit or lockdown bit decides, write-protect plays no part
      pe_prot   <= prot[pe_idx];
      o_pe_done <= pe_pend;
      o_pe_refused <= pe_pend & (nv_rd_bit | pe_prot);
    end
  end

  assign o_sector_prot                = prot;
  assign o_sector_lockdown            = nv_bits[NUM_SECTORS-1:0];
  assign o_write_enable_latch_bit     = write_enable_latch_bit;
  assign o_protection_regs_locked_bit = protection_regs_locked_bit;
  assign o_lockdown_enable_bit        = lockdown_enable_bit;
  assign o_lockdown_frozen            = frozen;
  assign o_hw_locked                  = hw_locked;
  assign o_sw_locked                  = protection_regs_locked_bit & ~wp_asserted;
  assign o_lock_busy                  = (commit_cnt != 16'h0000);

endmodule // slk_top

// ===== slk_defines.vh
// constants for the sector lock and lockdown block: opcodes, status fields, timing
// assumes it is included by every design file of the block, by bare name
`ifndef SLK_DEFINES_VH
`define SLK_DEFINES_VH

// serial command opcodes
`define SLK_OP_WRITE_ENABLE    8'h06
`define SLK_OP_WRITE_DISABLE   8'h04
`define SLK_OP_WRITE_STATUS1   8'h01
`define SLK_OP_WRITE_STATUS2   8'h31
`define SLK_OP_PROTECT_SECTOR  8'h36
`define SLK_OP_UNPROTECT_SECT  8'h39
`define SLK_OP_LOCKDOWN        8'h33
`define SLK_OP_FREEZE          8'h34

// confirmation byte and freeze key address
`define SLK_CONFIRM            8'hD0
`define SLK_FREEZE_ADDR        24'h55AA40

// status byte 1 fields
`define SLK_SR1_LOCKED_BIT     7
`define SLK_SR1_GLOBAL_MSB     5
`define SLK_SR1_GLOBAL_LSB     2
`define SLK_GLOBAL_UNPROTECT   4'h0
`define SLK_GLOBAL_PROTECT     4'hF

// status byte 2 field
`define SLK_SR2_LOCKDOWN_EN    4

// frame byte positions: opcode, three address bytes, confirmation
`define SLK_BYTES_OPCODE       3'h1
`define SLK_BYTES_STATUS       3'h2
`define SLK_BYTES_ADDRESS      3'h4
`define SLK_BYTES_CONFIRM      3'h5

// sector geometry: 64KB sectors
`define SLK_SECTOR_SHIFT       16
`define SLK_NUM_SECTORS        32
`define SLK_SECTOR_IDX_W       5
`define SLK_PROT_RESET         32'hFFFFFFFF

// timing
`define SLK_CLK_PERIOD_NS      40
`define SLK_LOCK_COMMIT_NS     200000

// synchroniser reset pattern for {sck, cs_n, si, wp_n}
`define SLK_PIN_RESET          4'h5

`endif

// ===== slk_sync.v
// three-stage synchroniser bank with agreement filter for pins from outside the clock domain
// assumes inputs are asynchronous levels; output moves only when stages two and three agree
`timescale 1ns/1ps
`include "slk_defines.vh"

module slk_sync #(
  parameter           W         = 4,
  parameter [W-1:0]   RESET_VAL = {W{1'b0}}
) (
  input  wire         i_clock,
  input  wire         i_rst_b,
  input  wire         i_clk_en,
  input  wire [W-1:0] i_async,
  output reg  [W-1:0] o_sync
);

  reg [W-1:0] stage1;
  reg [W-1:0] stage2;
  reg [W-1:0] stage3;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1)
    begin : g_bit
      always @(posedge i_clock or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          stage1[g] <= RESET_VAL[g];
          stage2[g] <= RESET_VAL[g];
          stage3[g] <= RESET_VAL[g];
          o_sync[g] <= RESET_VAL[g];
        end
        else if (i_clk_en)
        begin
          stage1[g] <= i_async[g];
          stage2[g] <= stage1[g];
          stage3[g] <= stage2[g];
          // one-cycle glitch past stage one is rejected here
          if (stage2[g] == stage3[g])
            o_sync[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule // slk_sync

// ===== slk_nvbits.v
// nonvolatile set-only bit store: one lockdown bit per sector plus the freeze bit
// assumes no reset reaches it; only the factory init input clears it
`timescale 1ns/1ps
`include "slk_defines.vh"

module slk_nvbits #(
  parameter N   = 33,
  parameter AW  = 6
) (
  input  wire          i_clock,
  input  wire          i_clk_en,
  input  wire          i_init,
  input  wire          i_set_we,
  input  wire [AW-1:0] i_set_idx,
  input  wire [AW-1:0] i_rd_idx,
  output reg           o_rd_bit,
  output reg  [N-1:0]  o_bits
);

  always @(posedge i_clock)
  begin
    if (i_clk_en)
    begin
      if (i_init)
        o_bits <= {N{1'b0}};
      // bits only ever go from 0 to 1
      else if (i_set_we)
        o_bits[i_set_idx] <= 1'b1;
      o_rd_bit <= o_bits[i_rd_idx];
    end
  end

endmodule // slk_nvbits

// ===== slk_top_assertions.sv
// port assertions for the sector lock and lockdown block
// assumes a bind onto slk_top and a single i_clock domain
`timescale 1ns/1ps
module slk_chk #(
  parameter NUM_SECTORS        = 32,
  parameter SECTOR_IDX_W       = 5,
  parameter LOCK_COMMIT_CYCLES = 5000
) (
  input wire logic                   i_clock,
  input wire logic                   i_rst_b,
  input wire logic                   i_nv_init,
  input wire logic                   i_pe_req,
  input wire logic [23:0]            i_pe_addr,
  input wire logic [NUM_SECTORS-1:0] o_sector_prot,
  input wire logic [NUM_SECTORS-1:0] o_sector_lockdown,
  input wire logic                   o_write_enable_latch_bit,
  input wire logic                   o_protection_regs_locked_bit,
  input wire logic                   o_lockdown_enable_bit,
  input wire logic                   o_lockdown_frozen,
  input wire logic                   o_hw_locked,
  input wire logic                   o_sw_locked,
  input wire logic                   o_lock_busy,
  input wire logic                   o_pe_done,
  input wire logic                   o_pe_refused
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  logic [15:0] busy_cnt;
  always_ff @(posedge i_clock or negedge i_rst_b)
    if (!i_rst_b)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= o_lock_busy ? busy_cnt + 16'h0001 : 16'h0000;
  hw_lock_bit_a: assert property ($past(o_hw_locked) |-> o_protection_regs_locked_bit)
    else $error("locked bit left hardware lock");
  sw_lock_def_a: assert property (o_sw_locked |-> o_protection_regs_locked_bit && !o_hw_locked)
    else $error("soft lock without locked bit");
  prot_frozen_a: assert property ($past(o_protection_regs_locked_bit) |-> $stable(o_sector_prot))
    else $error("protection changed while locked");
  lockdown_sticky_a: assert property (!$past(i_nv_init) |-> ($past(o_sector_lockdown) & ~o_sector_lockdown) == '0)
    else $error("lockdown bit cleared");
  lockdown_commit_a: assert property (!$past(i_nv_init) && o_sector_lockdown != $past(o_sector_lockdown)
    |-> ##[0:1] (o_lock_busy && !o_write_enable_latch_bit))
    else $error("lockdown set without commit");
  busy_len_a: assert property ($fell(o_lock_busy) |-> busy_cnt == 16'(LOCK_COMMIT_CYCLES))
    else $error("commit time wrong");
  pe_answer_a: assert property (i_pe_req |-> ##2 o_pe_done)
    else $error("check not answered");
  pe_cause_a: assert property (o_pe_done |-> $past(i_pe_req, 2))
    else $error("answer without request");
  pe_refuse_a: assert property (i_pe_req && (o_sector_lockdown[i_pe_addr[20:16]]
    || o_sector_prot[i_pe_addr[20:16]]) |-> ##2 o_pe_refused)
    else $error("locked sector not refused");
  pe_allow_a: assert property (i_pe_req && !o_sector_lockdown[i_pe_addr[20:16]]
    && !o_sector_prot[i_pe_addr[20:16]] |-> ##2 !o_pe_refused)
    else $error("free sector refused");
  freeze_en_a: assert property (o_lockdown_frozen && $past(o_lockdown_frozen) |-> !o_lockdown_enable_bit)
    else $error("enable set while frozen");
  freeze_keep_a: assert property ($fell(o_lockdown_frozen) |-> $past(i_nv_init))
    else $error("freeze bit cleared");
endmodule // slk_chk
bind slk_top slk_chk #(.NUM_SECTORS(NUM_SECTORS), .SECTOR_IDX_W(SECTOR_IDX_W),
  .LOCK_COMMIT_CYCLES(LOCK_COMMIT_CYCLES)) i_slk_chk (.i_clock, .i_rst_b, .i_nv_init,
  .i_pe_req, .i_pe_addr, .o_sector_prot, .o_sector_lockdown, .o_write_enable_latch_bit,
  .o_protection_regs_locked_bit, .o_lockdown_enable_bit, .o_lockdown_frozen, .o_hw_locked,
  .o_sw_locked, .o_lock_busy, .o_pe_done, .o_pe_refused);

// ===== slk_host.sv
// serial host model driving chip select, serial clock and data in
// assumes the block oversamples these pins; clock idles low, data msb first
`timescale 1ns/1ps
module slk_host (
  output logic o_sck,
  output logic o_cs_n,
  output logic o_si
);
  initial
  begin
    o_sck  = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end
  task automatic send(input logic [47:0] f, input int n);
    #7 o_cs_n = 1'b0;
    for (int b = 0; b < n; b++)
    begin
      o_si = f[47-b];
      #160 o_sck = 1'b1;
      #160 o_sck = 1'b0;
    end
    #160 o_cs_n = 1'b1;
    // a released line must not keep showing the last bit
    o_si = ~o_si;
    #800;
  endtask
endmodule // slk_host

// ===== slk_top_tb.sv
// self-checking bench for the sector lock and lockdown block
// assumes slk_host drives the serial pins and the checker is bound in
`timescale 1ns/1ps
module slk_top_tb;
  logic        i_clock, i_rst_b, i_clk_en, i_spi_sck, i_spi_cs_n, i_spi_si;
  logic        i_wp_n, i_nv_init, i_pe_req;
  logic [23:0] i_pe_addr, a;
  logic [31:0] o_sector_prot, o_sector_lockdown;
  logic        o_write_enable_latch_bit, o_protection_regs_locked_bit, o_lockdown_enable_bit;
  logic        o_lockdown_frozen, o_hw_locked, o_sw_locked, o_lock_busy, o_pe_done, o_pe_refused;
  logic [4:0]  s;
  logic        q[$];
  int          n_mismatch = 0;
  int          cmp_count = 0;
  integer      seed = 32'h2bef315f;
  slk_top #(.LOCK_COMMIT_CYCLES(8)) i_slk_top (.i_clock, .i_rst_b, .i_clk_en, .i_spi_sck,
    .i_spi_cs_n, .i_spi_si, .i_wp_n, .i_nv_init, .i_pe_req, .i_pe_addr, .o_sector_prot,
    .o_sector_lockdown, .o_write_enable_latch_bit, .o_protection_regs_locked_bit,
    .o_lockdown_enable_bit, .o_lockdown_frozen, .o_hw_locked, .o_sw_locked, .o_lock_busy,
    .o_pe_done, .o_pe_refused);
  slk_host i_slk_host (.o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n), .o_si(i_spi_si));
  initial
  begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // order: latch, locked, enable, frozen, hardware lock, soft lock
  task automatic flags(input logic [5:0] e);
    chk({o_write_enable_latch_bit, o_protection_regs_locked_bit, o_lockdown_enable_bit,
      o_lockdown_frozen, o_hw_locked, o_sw_locked}, e);
  endtask
  task automatic wcmd(input logic [47:0] f, input int n);
    i_slk_host.send(48'h060000000000, 8);
    i_slk_host.send(f, n);
  endtask
  function automatic logic [23:0] sa(input logic [4:0] k);
    return {3'b000, k, 16'($random(seed))};
  endfunction
  task automatic pe(input logic [23:0] ad, input logic e);
    @(posedge i_clock);
    i_pe_req  <= 1'b1;
    i_pe_addr <= ad;
    q.push_back(e);
  endtask
  task automatic pe_end;
    @(posedge i_clock);
    i_pe_req <= 1'b0;
    repeat (4) @(posedge i_clock);
  endtask
  task automatic do_reset;
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clock);
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge i_clock)
    if (o_pe_done === 1'b1)
    begin
      if (q.size() == 0)
        chk(32'h1, 32'h0);
      else
        chk(o_pe_refused, q.pop_front());
    end
  initial
  begin
    #3000000;
    n_mismatch++;
    end_sim;
  end
  initial
  begin
    i_rst_b   = 1'b0;
    i_clk_en  = 1'b1;
    i_wp_n    = 1'b1;
    i_nv_init = 1'b1;
    i_pe_req  = 1'b0;
    i_pe_addr = 24'h000000;
    repeat (6) @(posedge i_clock);
    i_nv_init <= 1'b0;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (12) @(posedge i_clock);
    chk(o_sector_prot, 32'hFFFFFFFF);
    chk(o_sector_lockdown, 32'h0);
    flags(6'b000000);
    pe(sa(5'h03), 1'b1);
    pe_end;
    wcmd({8'h01, 8'h00, 32'h0}, 16);
    chk(o_sector_prot, 32'h0);
    wcmd({8'h33, sa(5'h07), 8'hD0, 8'h00}, 40);
    chk(o_sector_lockdown, 32'h0);
    flags(6'b000000);
    wcmd({8'h31, 8'h10, 32'h0}, 16);
    a = sa(5'h0C);
    for (int k = 0; k < 4; k++)
    begin
      i_slk_host.send(48'h060000000000, 8);
      flags(6'b101000);
      case (k)
        0: i_slk_host.send({8'h33, a, 16'h0}, 24);
        1: i_slk_host.send({8'h33, a, 16'h0}, 32);
        2: i_slk_host.send({8'h33, a, 8'hC0, 8'h0}, 40);
        default: i_slk_host.send({8'h33, a, 8'hD0, 8'h0}, 44);
      endcase
      flags(6'b001000);
      chk(o_sector_lockdown, 32'h0);
    end
    s = 5'($random(seed));
    a = sa(s);
    wcmd({8'h33, a, 8'hD0, 8'h5A}, 48);
    chk(o_sector_lockdown, 32'h1 << s);
    flags(6'b001000);
    pe(a, 1'b1);
    pe(sa(s + 5'h01), 1'b0);
    pe_end;
    wcmd({8'h01, 8'hBC, 32'h0}, 16);
    chk(o_sector_prot, 32'hFFFFFFFF);
    flags(6'b011001);
    wcmd({8'h39, sa(5'h02), 16'h0}, 32);
    chk(o_sector_prot, 32'hFFFFFFFF);
    @(posedge i_clock);
    i_wp_n <= 1'b0;
    repeat (10) @(posedge i_clock);
    flags(6'b011010);
    wcmd({8'h01, 8'h00, 32'h0}, 16);
    chk(o_sector_prot, 32'hFFFFFFFF);
    flags(6'b011010);
    @(posedge i_clock);
    i_wp_n <= 1'b1;
    repeat (10) @(posedge i_clock);
    wcmd({8'h01, 8'h00, 32'h0}, 16);
    chk(o_sector_prot, 32'hFFFFFFFF);
    flags(6'b001000);
    wcmd({8'h01, 8'h00, 32'h0}, 16);
    wcmd({8'h36, sa(5'h09), 16'h0}, 32);
    chk(o_sector_prot, 32'h00000200);
    wcmd({8'h34, 24'h55AA40, 8'hD0, 8'h0}, 40);
    flags(6'b000100);
    wcmd({8'h31, 8'h10, 32'h0}, 16);
    flags(6'b000100);
    wcmd({8'h33, sa(s + 5'h02), 8'hD0, 8'h0}, 40);
    chk(o_sector_lockdown, 32'h1 << s);
    do_reset;
    chk(o_sector_lockdown, 32'h1 << s);
    flags(6'b000100);
    wcmd({8'h01, 8'h00, 32'h0}, 16);
    pe(a, 1'b1);
    pe(sa(s + 5'h03), 1'b0);
    pe_end;
    chk(o_sector_lockdown, 32'h1 << s);
    end_sim;
  end
endmodule // slk_top_tb
